/* core/crf_core.sv */
// Function
// RL1 - Thirteen visible registers, bank counted once
// RL2 - Two full banks of data, address, frame
// RL3 - Sixteen-bit data; regs zero/one split into bytes
// RL4 - Data two:zero and three:one form pairs
// RL5 - Sixteen-bit address registers; one:zero form pair
// RL6 - Sixteen-bit frame base register
// RL7 - Twenty-bit vector table base register
// RL8 - Twenty-bit program counter
// RL9 - Two sixteen-bit stack pointers
// RL10 - Sixteen-bit static base register
// RL11 - Eleven-bit state flag register
// RL12 - Carry flag captures ALU carry out
// RL13 - Software keeps debug flag at zero
// RL14 - Zero flag set on zero result
// RL15 - Sign flag set on negative result
// RL16 - Bank flag selects register bank
// RL17 - Overflow flag follows operation overflow
// RL18 - Enable flag gates maskable interrupts
// RL19 - Acknowledge clears interrupt enable flag
// RL20 - Stack flag picks interrupt or user pointer
// RL21 - Hardware acknowledge, low software numbers clear stack
// RL22 - Accept only priority above current level
// RL23 - Reserved flag bit written zero, reads undefined
// RL24 - Reset clears all state flags
//
// Register access over AHB-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module crf_core (
    input wire logic clk,
    input wire logic sys_rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [crf_pkg::DATA_W-1:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [crf_pkg::DATA_W-1:0] hrdata,
    // Datapath write port
    input wire logic dp_wr_en,
    input wire crf_pkg::crf_sel_t dp_wr_sel,
    input wire logic [crf_pkg::DATA_W-1:0] dp_wr_data,
    // Datapath read port
    input wire crf_pkg::crf_sel_t dp_rd_sel,
    output logic [crf_pkg::DATA_W-1:0] dp_rd_data,
    // ALU flag update
    input wire logic alu_flag_we,
    input wire crf_pkg::crf_size_t alu_size,
    input wire logic [crf_pkg::DATA_W-1:0] alu_result,
    input wire logic alu_carry,
    input wire logic alu_ovfl,
    // Interrupt request and software interrupt
    input wire logic irq_req,
    input wire logic [crf_pkg::PRIO_W-1:0] irq_prio,
    output logic irq_ack,
    input wire logic swi_exec,
    input wire logic [crf_pkg::SWI_W-1:0] swi_num,
    // State views
    output logic [crf_pkg::FLAG_W-1:0] cpu_state_flags,
    output logic [crf_pkg::WIDE_W-1:0] program_counter
);
    import crf_pkg::*;
    // Banked registers: [bank][slot]
    logic [REG_W-1:0] bank_r [2][BANK_REGS]; // RL1 RL2
    logic [WIDE_W-1:0] vector_table_base_r; // RL7
    logic [WIDE_W-1:0] program_counter_r; // RL8
    logic [REG_W-1:0] user_stack_pointer_r; // RL9
    logic [REG_W-1:0] interrupt_stack_pointer_r;
    logic [REG_W-1:0] static_base_r; // RL10
    logic [FLAG_W-1:0] flags_r; // RL11
    logic [FLAG_W-1:0] flags_nxt;

    // Bus slave state
    crf_bus_st_t bus_st_r; // Read wait tracking
    logic bus_wr_r; // Write data phase pending
    logic bus_hit_r; // Captured address is mapped
    crf_sel_t bus_sel_r; // Captured register selector
    logic [DATA_W-1:0] hrdata_r;
    logic hreadyout_r;
    logic hresp_r;
    logic [DATA_W-1:0] dp_rd_data_r;
    logic irq_ack_r;

    // Unified write port
    logic wr_en;
    crf_sel_t wr_sel;
    logic [DATA_W-1:0] wr_data;
    logic [7:0] wr_byte; // Byte lane for half-register writes
    // Decode helpers
    logic bank_q; // Active bank
    logic take; // Bus transfer accepted
    logic irq_take; // Interrupt accepted this cycle
    logic hit_nxt;
    crf_sel_t sel_nxt;
    assign bank_q = flags_r[BIT_BANK]; // RL16
    assign wr_byte = wr_data[7:0];
    // Register contents by selector
    function automatic logic [DATA_W-1:0] read_sel(input crf_sel_t s);
        logic [DATA_W-1:0] v;
        v = '0;
        case (s)
            SEL_DATA_ZERO: v = 32'(bank_r[bank_q][IDX_D0]);
            SEL_DATA_ONE: v = 32'(bank_r[bank_q][IDX_D1]);
            SEL_DATA_TWO: v = 32'(bank_r[bank_q][IDX_D2]);
            SEL_DATA_THREE: v = 32'(bank_r[bank_q][IDX_D3]);
            SEL_ADDR_ZERO: v = 32'(bank_r[bank_q][IDX_ADDR0]);
            SEL_ADDR_ONE: v = 32'(bank_r[bank_q][IDX_ADDR1]);
            SEL_FRAME_BASE: v = 32'(bank_r[bank_q][IDX_FRAME]); // RL6
            SEL_STATIC_BASE: v = 32'(static_base_r);
            SEL_USER_STACK: v = 32'(user_stack_pointer_r);
            SEL_INT_STACK: v = 32'(interrupt_stack_pointer_r);
            // Active pointer follows stack flag
            SEL_STACK_ACT: v = flags_r[BIT_STACK] ? 32'(user_stack_pointer_r)
                : 32'(interrupt_stack_pointer_r); // RL20
            SEL_VECTOR_BASE: v = 32'(vector_table_base_r);
            SEL_PROG_COUNT: v = 32'(program_counter_r);
            // Reserved bit above the flags reads zero
            SEL_STATE_FLAGS: v = 32'(flags_r); // RL23
            SEL_D0_LOWER: v = 32'(bank_r[bank_q][IDX_D0][7:0]);
            SEL_D0_UPPER: v = 32'(bank_r[bank_q][IDX_D0][15:8]);
            SEL_D1_LOWER: v = 32'(bank_r[bank_q][IDX_D1][7:0]);
            SEL_D1_UPPER: v = 32'(bank_r[bank_q][IDX_D1][15:8]);
            SEL_PAIR_LOW: v = {bank_r[bank_q][IDX_D2],
                bank_r[bank_q][IDX_D0]}; // RL4
            SEL_PAIR_HIGH: v = {bank_r[bank_q][IDX_D3],
                bank_r[bank_q][IDX_D1]}; // RL4
            SEL_ADDR_PAIR: v = {bank_r[bank_q][IDX_ADDR1],
                bank_r[bank_q][IDX_ADDR0]}; // RL5
            default: v = '0;
        endcase
        return v;
    endfunction : read_sel
    // Result is zero within operand size
    function automatic logic res_zero(input logic [DATA_W-1:0] r,
                                      input crf_size_t sz);
        case (sz)
            SIZE_BYTE: return r[7:0] == 8'h00;
            SIZE_WORD: return r[15:0] == 16'h0000;
            default: return r == 32'h00000000;
        endcase
    endfunction : res_zero
    // Sign bit within operand size
    function automatic logic res_sign(input logic [DATA_W-1:0] r,
                                      input crf_size_t sz);
        case (sz)
            SIZE_BYTE: return r[7];
            SIZE_WORD: return r[15];
            default: return r[31];
        endcase
    endfunction : res_sign
    // Address decode, word aligned, low byte only
    always_comb begin
        hit_nxt = 1'b1;
        sel_nxt = SEL_DATA_ZERO;
        case ({haddr[7:2], 2'b00})
            OFS_DATA_ZERO: sel_nxt = SEL_DATA_ZERO;
            OFS_DATA_ONE: sel_nxt = SEL_DATA_ONE;
            OFS_DATA_TWO: sel_nxt = SEL_DATA_TWO;
            OFS_DATA_THREE: sel_nxt = SEL_DATA_THREE;
            OFS_ADDR_ZERO: sel_nxt = SEL_ADDR_ZERO;
            OFS_ADDR_ONE: sel_nxt = SEL_ADDR_ONE;
            OFS_FRAME_BASE: sel_nxt = SEL_FRAME_BASE;
            OFS_VECTOR_BASE: sel_nxt = SEL_VECTOR_BASE;
            OFS_PROG_COUNT: sel_nxt = SEL_PROG_COUNT;
            OFS_USER_STACK: sel_nxt = SEL_USER_STACK;
            OFS_INT_STACK: sel_nxt = SEL_INT_STACK;
            OFS_STATIC_BASE: sel_nxt = SEL_STATIC_BASE;
            OFS_STATE_FLAGS: sel_nxt = SEL_STATE_FLAGS;
            default: hit_nxt = 1'b0; // Unmapped: reads zero
        endcase
    end
    assign take = hsel && htrans[1] && hready;
    // Bus slave: zero-wait writes, one-wait reads
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bus_st_r <= BUS_IDLE;
            bus_wr_r <= 1'b0;
            bus_hit_r <= 1'b0;
            bus_sel_r <= SEL_DATA_ZERO;
            hreadyout_r <= 1'b1;
            hrdata_r <= 32'h00000000;
            hresp_r <= 1'b0;
        end else begin
            case (bus_st_r)
                BUS_IDLE: begin
                    bus_wr_r <= take && hwrite;
                    if (take) begin
                        bus_hit_r <= hit_nxt;
                        bus_sel_r <= sel_nxt;
                    end
                    // Read waits one cycle so a prior write lands first
                    if (take && !hwrite) begin
                        bus_st_r <= BUS_RDWAIT;
                        hreadyout_r <= 1'b0;
                    end
                end
                BUS_RDWAIT: begin
                    bus_wr_r <= 1'b0;
                    hrdata_r <= bus_hit_r ? read_sel(bus_sel_r) : '0;
                    hreadyout_r <= 1'b1;
                    bus_st_r <= BUS_IDLE;
                end
                default: begin
                    bus_st_r <= BUS_IDLE;
                    hreadyout_r <= 1'b1;
                end
            endcase
        end
    end

    // Write source: datapath wins over a same-cycle bus write
    always_comb begin
        wr_en = 1'b0;
        wr_sel = dp_wr_sel;
        wr_data = dp_wr_data;
        if (dp_wr_en) begin
            wr_en = 1'b1;
        end else if (bus_wr_r && bus_hit_r) begin
            wr_en = 1'b1;
            wr_sel = bus_sel_r;
            wr_data = hwdata;
        end
    end

    // Banked register writes into the active bank
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int b = 0; b < 2; b++) begin
                for (int i = 0; i < BANK_REGS; i++) begin
                    bank_r[b][i] <= REG_RST;
                end
            end
        end else if (wr_en) begin
            case (wr_sel)
                SEL_DATA_ZERO: bank_r[bank_q][IDX_D0] <= wr_data[15:0]; // RL16
                SEL_DATA_ONE: bank_r[bank_q][IDX_D1] <= wr_data[15:0];
                SEL_DATA_TWO: bank_r[bank_q][IDX_D2] <= wr_data[15:0];
                SEL_DATA_THREE: bank_r[bank_q][IDX_D3] <= wr_data[15:0];
                SEL_ADDR_ZERO: bank_r[bank_q][IDX_ADDR0] <= wr_data[15:0];
                SEL_ADDR_ONE: bank_r[bank_q][IDX_ADDR1] <= wr_data[15:0];
                SEL_FRAME_BASE: bank_r[bank_q][IDX_FRAME] <= wr_data[15:0];
                // Byte halves leave the other half intact
                SEL_D0_LOWER: bank_r[bank_q][IDX_D0][7:0] <= wr_byte; // RL3
                SEL_D0_UPPER: bank_r[bank_q][IDX_D0][15:8] <= wr_byte; // RL3
                SEL_D1_LOWER: bank_r[bank_q][IDX_D1][7:0] <= wr_byte; // RL3
                SEL_D1_UPPER: bank_r[bank_q][IDX_D1][15:8] <= wr_byte; // RL3
                SEL_PAIR_LOW: begin
                    bank_r[bank_q][IDX_D0] <= wr_data[15:0]; // RL4
                    bank_r[bank_q][IDX_D2] <= wr_data[31:16];
                end
                SEL_PAIR_HIGH: begin
                    bank_r[bank_q][IDX_D1] <= wr_data[15:0]; // RL4
                    bank_r[bank_q][IDX_D3] <= wr_data[31:16];
                end
                SEL_ADDR_PAIR: begin
                    bank_r[bank_q][IDX_ADDR0] <= wr_data[15:0]; // RL5
                    bank_r[bank_q][IDX_ADDR1] <= wr_data[31:16];
                end
                default: ;
            endcase
        end
    end

    // Unbanked registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            vector_table_base_r <= WIDE_RST;
            program_counter_r <= WIDE_RST;
            user_stack_pointer_r <= REG_RST;
            interrupt_stack_pointer_r <= REG_RST;
            static_base_r <= REG_RST;
        end else if (wr_en) begin
            case (wr_sel)
                SEL_VECTOR_BASE: vector_table_base_r <= wr_data[19:0]; // RL7
                SEL_PROG_COUNT: program_counter_r <= wr_data[19:0]; // RL8
                SEL_USER_STACK: user_stack_pointer_r <= wr_data[15:0]; // RL9
                SEL_INT_STACK: interrupt_stack_pointer_r <= wr_data[15:0];
                // Active pointer write follows stack flag
                SEL_STACK_ACT: begin
                    if (flags_r[BIT_STACK]) begin
                        user_stack_pointer_r <= wr_data[15:0]; // RL20
                    end else begin
                        interrupt_stack_pointer_r <= wr_data[15:0]; // RL20
                    end
                end
                SEL_STATIC_BASE: static_base_r <= wr_data[15:0]; // RL10
                default: ;
            endcase
        end
    end

    // Interrupt accepted when enabled and above current level
    assign irq_take = irq_req && flags_r[BIT_IRQ_EN] &&
        (irq_prio > flags_r[BIT_PRIO_HI:BIT_PRIO_LO]); // RL18 RL22
    // Flag next value; later sources override earlier ones
    always_comb begin
        flags_nxt = flags_r;
        // Plain write; reserved bit is not stored
        if (wr_en && wr_sel == SEL_STATE_FLAGS) begin
            flags_nxt = wr_data[FLAG_W-1:0]; // RL23
        end
        // ALU result flags
        if (alu_flag_we) begin
            flags_nxt[BIT_CARRY] = alu_carry; // RL12
            flags_nxt[BIT_ZERO] = res_zero(alu_result, alu_size); // RL14
            flags_nxt[BIT_SIGN] = res_sign(alu_result, alu_size); // RL15
            flags_nxt[BIT_OVFL] = alu_ovfl; // RL17
        end
        // Software interrupt entry
        if (swi_exec) begin
            flags_nxt[BIT_IRQ_EN] = 1'b0; // RL19
            if (swi_num <= SWI_STACK_MAX) begin
                flags_nxt[BIT_STACK] = 1'b0; // RL21
            end
        end
        // Hardware interrupt acknowledge
        if (irq_take) begin
            flags_nxt[BIT_IRQ_EN] = 1'b0; // RL19
            flags_nxt[BIT_STACK] = 1'b0; // RL21
        end
    end

    // Flag register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flags_r <= FLAGS_RST; // RL24
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // Acknowledge pulse and datapath read
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_ack_r <= 1'b0;
            dp_rd_data_r <= 32'h00000000;
        end else begin
            irq_ack_r <= irq_take;
            dp_rd_data_r <= read_sel(dp_rd_sel);
        end
    end

    // Output drive
    assign hreadyout = hreadyout_r;
    assign hresp = hresp_r;
    assign hrdata = hrdata_r;
    assign dp_rd_data = dp_rd_data_r;
    assign irq_ack = irq_ack_r;
    assign cpu_state_flags = flags_r;
    assign program_counter = program_counter_r;

    // Checks
    chk_irq_clear_ie: assert property (@(posedge clk) disable iff (sys_rst)
        irq_take |=> !flags_r[BIT_IRQ_EN] && !flags_r[BIT_STACK]) // RL19
        else $error("interrupt accept did not clear enable and stack");
    chk_irq_prio_gate: assert property (@(posedge clk) disable iff (sys_rst)
        irq_ack_r |-> $past(flags_r[BIT_IRQ_EN]) &&
        ($past(irq_prio) > $past(flags_r[BIT_PRIO_HI:BIT_PRIO_LO]))) // RL22
        else $error("interrupt acknowledged without enough priority");
    chk_swi_stack_clr: assert property (@(posedge clk) disable iff (sys_rst)
        swi_exec && swi_num <= SWI_STACK_MAX |=> !flags_r[BIT_STACK]) // RL21
        else $error("low software interrupt kept user stack");
    chk_zero_word: assert property (@(posedge clk) disable iff (sys_rst)
        alu_flag_we && alu_size == SIZE_WORD |=>
        flags_r[BIT_ZERO] == ($past(alu_result[15:0]) == 16'h0000)) // RL14
        else $error("zero flag wrong for word result");
    chk_sign_long: assert property (@(posedge clk) disable iff (sys_rst)
        alu_flag_we && alu_size == SIZE_LONG |=>
        flags_r[BIT_SIGN] == $past(alu_result[31])) // RL15
        else $error("sign flag wrong for long result");
    chk_carry_ovfl: assert property (@(posedge clk) disable iff (sys_rst)
        alu_flag_we |=> flags_r[BIT_CARRY] == $past(alu_carry) &&
        flags_r[BIT_OVFL] == $past(alu_ovfl)) // RL12 RL17
        else $error("carry or overflow flag not captured");
    chk_bank_write: assert property (@(posedge clk) disable iff (sys_rst)
        dp_wr_en && dp_wr_sel == SEL_DATA_ZERO |=>
        bank_r[$past(bank_q)][IDX_D0] == $past(dp_wr_data[15:0])) // RL16
        else $error("data write missed the selected bank");
    chk_upper_byte: assert property (@(posedge clk) disable iff (sys_rst)
        dp_wr_en && dp_wr_sel == SEL_D0_UPPER |=>
        bank_r[$past(bank_q)][IDX_D0] == {$past(dp_wr_data[7:0]),
        $past(bank_r[bank_q][IDX_D0][7:0])}) // RL3
        else $error("upper byte write disturbed lower byte");
    chk_pair_write: assert property (@(posedge clk) disable iff (sys_rst)
        dp_wr_en && dp_wr_sel == SEL_PAIR_LOW |=>
        {bank_r[$past(bank_q)][IDX_D2], bank_r[$past(bank_q)][IDX_D0]}
        == $past(dp_wr_data)) // RL4
        else $error("wide data pair write split wrong");
    chk_stack_active: assert property (@(posedge clk) disable iff (sys_rst)
        dp_wr_en && dp_wr_sel == SEL_STACK_ACT && !flags_r[BIT_STACK] |=>
        interrupt_stack_pointer_r == $past(dp_wr_data[15:0])) // RL20
        else $error("active stack write missed interrupt pointer");
    chk_bus_rd_wait: assert property (@(posedge clk) disable iff (sys_rst)
        take && !hwrite |=> !hreadyout_r ##1 hreadyout_r)
        else $error("read did not take exactly one wait cycle");
endmodule : crf_core

/* core/crf_pkg.sv */
package crf_pkg;

    // Widths
    localparam int DATA_W = 32;   // Bus and operand width
    localparam int REG_W = 16;    // Data, address, base, stack width
    localparam int WIDE_W = 20;   // Counter and vector base width
    localparam int FLAG_W = 11;   // Stored state flags
    localparam int BANK_REGS = 7; // Registers in one bank
    localparam int PRIO_W = 3;    // Priority level width
    localparam int SWI_W = 6;     // Software interrupt number width

    // Bank slot indices
    localparam int IDX_D0 = 0;
    localparam int IDX_D1 = 1;
    localparam int IDX_D2 = 2;
    localparam int IDX_D3 = 3;
    localparam int IDX_ADDR0 = 4;
    localparam int IDX_ADDR1 = 5;
    localparam int IDX_FRAME = 6;

    // Bus byte offsets
    localparam logic [7:0] OFS_DATA_ZERO = 8'h00;
    localparam logic [7:0] OFS_DATA_ONE = 8'h04;
    localparam logic [7:0] OFS_DATA_TWO = 8'h08;
    localparam logic [7:0] OFS_DATA_THREE = 8'h0C;
    localparam logic [7:0] OFS_ADDR_ZERO = 8'h10;
    localparam logic [7:0] OFS_ADDR_ONE = 8'h14;
    localparam logic [7:0] OFS_FRAME_BASE = 8'h18;
    localparam logic [7:0] OFS_VECTOR_BASE = 8'h1C;
    localparam logic [7:0] OFS_PROG_COUNT = 8'h20;
    localparam logic [7:0] OFS_USER_STACK = 8'h24;
    localparam logic [7:0] OFS_INT_STACK = 8'h28;
    localparam logic [7:0] OFS_STATIC_BASE = 8'h2C;
    localparam logic [7:0] OFS_STATE_FLAGS = 8'h30;

    // State flag bit positions
    localparam int BIT_CARRY = 0;
    localparam int BIT_DEBUG = 1;
    localparam int BIT_ZERO = 2;
    localparam int BIT_SIGN = 3;
    localparam int BIT_BANK = 4;
    localparam int BIT_OVFL = 5;
    localparam int BIT_IRQ_EN = 6;
    localparam int BIT_STACK = 7;
    localparam int BIT_PRIO_LO = 8;
    localparam int BIT_PRIO_HI = 10;

    // Reset values
    localparam logic [FLAG_W-1:0] FLAGS_RST = 11'h000;
    localparam logic [REG_W-1:0] REG_RST = 16'h0000;
    localparam logic [WIDE_W-1:0] WIDE_RST = 20'h00000;

    // Highest software interrupt number that forces the interrupt stack
    localparam logic [SWI_W-1:0] SWI_STACK_MAX = 6'h1F;

    // Register selector for datapath and bus access
    typedef enum logic [4:0] {
        SEL_DATA_ZERO = 5'h00, SEL_DATA_ONE = 5'h01,
        SEL_DATA_TWO = 5'h02, SEL_DATA_THREE = 5'h03,
        SEL_ADDR_ZERO = 5'h04, SEL_ADDR_ONE = 5'h05,
        SEL_FRAME_BASE = 5'h06, SEL_STATIC_BASE = 5'h07,
        SEL_USER_STACK = 5'h08, SEL_INT_STACK = 5'h09,
        SEL_STACK_ACT = 5'h0A, SEL_VECTOR_BASE = 5'h0B,
        SEL_PROG_COUNT = 5'h0C, SEL_STATE_FLAGS = 5'h0D,
        SEL_D0_LOWER = 5'h0E, SEL_D0_UPPER = 5'h0F,
        SEL_D1_LOWER = 5'h10, SEL_D1_UPPER = 5'h11,
        SEL_PAIR_LOW = 5'h12, SEL_PAIR_HIGH = 5'h13,
        SEL_ADDR_PAIR = 5'h14
    } crf_sel_t;

    // Operand size for flag evaluation
    typedef enum logic [1:0] {
        SIZE_BYTE = 2'h0, SIZE_WORD = 2'h1, SIZE_LONG = 2'h2
    } crf_size_t;

    // Bus slave state, one-hot
    typedef enum logic [1:0] {
        BUS_IDLE = 2'h1, BUS_RDWAIT = 2'h2
    } crf_bus_st_t;

endpackage : crf_pkg

/* testbench/crf_dp_model.sv */
`timescale 1ns/1ps
// Datapath and interrupt side that drives the register file
module crf_dp_model (
    input wire logic clk,
    input wire logic irq_ack,
    output logic dp_wr_en,
    output crf_pkg::crf_sel_t dp_wr_sel,
    output logic [crf_pkg::DATA_W-1:0] dp_wr_data,
    output logic alu_flag_we,
    output crf_pkg::crf_size_t alu_size,
    output logic [crf_pkg::DATA_W-1:0] alu_result,
    output logic alu_carry,
    output logic alu_ovfl,
    output logic irq_req,
    output logic [crf_pkg::PRIO_W-1:0] irq_prio,
    output logic swi_exec,
    output logic [crf_pkg::SWI_W-1:0] swi_num
);
    import crf_pkg::*;
    // Quiet state at time zero
    initial begin
        {dp_wr_en, alu_flag_we, irq_req, swi_exec} = 4'h0;
        {dp_wr_data, alu_result, alu_carry, alu_ovfl} = 66'h0;
        {irq_prio, swi_num} = 9'h000;
        dp_wr_sel = SEL_DATA_ZERO;
        alu_size = SIZE_BYTE;
    end
    // One register write; data lines scrambled when released
    task wr(input crf_sel_t s, input logic [31:0] d);
        @(posedge clk);
        dp_wr_en <= 1'b1;
        dp_wr_sel <= s;
        dp_wr_data <= (s == SEL_STATE_FLAGS) ? (d & 32'h7FD) : d;
        @(posedge clk);
        dp_wr_en <= 1'b0;
        dp_wr_data <= ~dp_wr_data;
    endtask : wr
    // One flag update from an ALU operation
    task alu(input crf_size_t z, input logic [31:0] r, input logic c, o);
        @(posedge clk);
        alu_size <= z;
        {alu_flag_we, alu_result, alu_carry, alu_ovfl} <= {1'b1, r, c, o};
        @(posedge clk);
        alu_flag_we <= 1'b0;
        alu_result <= ~alu_result;
        #1; // Flags settle before the check
    endtask : alu
    // Request held as a level for four edges; reports an acknowledge
    task irq(input logic [2:0] p, output logic ok);
        @(posedge clk);
        irq_req <= 1'b1;
        irq_prio <= p;
        ok = 1'b0;
        repeat (4) begin
            @(posedge clk);
            if (irq_ack === 1'b1) ok = 1'b1;
        end
        irq_req <= 1'b0;
    endtask : irq
    // Software interrupt pulse
    task swi(input logic [5:0] n);
        @(posedge clk);
        swi_exec <= 1'b1;
        swi_num <= n;
        @(posedge clk);
        swi_exec <= 1'b0;
        #1; // Flags settle before the check
    endtask : swi
endmodule : crf_dp_model

/* testbench/tb.sv */
`timescale 1ns/1ps
// Self-checking bench for the register file
module tb;
    import crf_pkg::*;
    logic clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, ok;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, v, rd, rng = 32'hC603;
    logic [1:0] htrans = 2'h0;
    logic hreadyout, hresp, dp_wr_en, alu_flag_we, alu_carry, alu_ovfl;
    logic irq_req, irq_ack, swi_exec;
    logic [31:0] hrdata, dp_wr_data, dp_rd_data, alu_result;
    logic [2:0] irq_prio;
    logic [5:0] swi_num;
    logic [10:0] flags;
    logic [19:0] pc;
    crf_sel_t dp_wr_sel, dp_rd_sel = SEL_DATA_ZERO;
    crf_size_t alu_size;
    int mismatches = 0, checked = 0;
    always #20 clk = ~clk; // 25 MHz
    crf_core crf_core_i (.clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
        .hrdata, .dp_wr_en, .dp_wr_sel, .dp_wr_data, .dp_rd_sel, .dp_rd_data,
        .alu_flag_we, .alu_size, .alu_result, .alu_carry, .alu_ovfl,
        .irq_req, .irq_prio, .irq_ack, .swi_exec, .swi_num,
        .cpu_state_flags(flags), .program_counter(pc));
    crf_dp_model crf_dp_model_i (.clk, .irq_ack, .dp_wr_en, .dp_wr_sel,
        .dp_wr_data, .alu_flag_we, .alu_size, .alu_result, .alu_carry,
        .alu_ovfl, .irq_req, .irq_prio, .swi_exec, .swi_num);
    // Repeatable pseudo-random source
    function logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : xs
    // Implemented bits of the register at word index i
    function logic [31:0] msk(int i);
        return (i == 7 || i == 8) ? 32'hFFFFF : (i == 12) ? 32'h7FF :
            32'hFFFF;
    endfunction : msk
    // Expected {O,S,Z,C} after an ALU update
    function logic [3:0] fexp(crf_size_t z, logic [31:0] r, logic c, o);
        logic [31:0] m;
        m = (z == SIZE_BYTE) ? 32'hFF : (z == SIZE_WORD) ? 32'hFFFF : '1;
        return {o, r[(z == SIZE_BYTE) ? 7 : (z == SIZE_WORD) ? 15 : 31],
            (r & m) == 32'h0, c};
    endfunction : fexp
    task chk(string n, logic [31:0] e, logic [31:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // Bus single transfer: address phase, then data phase
    task ahb(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        {htrans, hwrite, haddr} <= {2'h2, w, 24'h0, a};
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : ahb
    // Registered datapath read
    task dprd(crf_sel_t s, output logic [31:0] q);
        @(posedge clk);
        dp_rd_sel <= s;
        repeat (2) @(posedge clk);
        q = dp_rd_data;
    endtask : dprd
    task results();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : results
    // Watchdog, well past the length of the run
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        results();
    end
    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        hsel <= 1'b1;
        chk("flags_rst", 32'h0, {21'h0, flags});
        chk("pc_rst", 32'h0, {12'h0, pc});
        for (int i = 0; i < 13; i++) begin
            v = (i == 12) ? (xs() & 32'h7FD) : xs();
            ahb(1'b1, 8'(i * 4), v, rd);
            ahb(1'b0, 8'(i * 4), 32'h0, rd);
            chk("bus_reg", v & msk(i), rd & msk(i));
            chk("bus_hi", 32'h0, rd & ~msk(i) & 32'hFFFFF7FF);
        end
        ahb(1'b0, 8'h34, 32'h0, rd);
        chk("unmapped", 32'h0, rd);
        ahb(1'b1, 8'h30, 32'h0, rd);
        v = xs();
        ahb(1'b1, 8'h00, v, rd);
        ahb(1'b1, 8'h30, 32'h10, rd);
        ahb(1'b1, 8'h00, ~v, rd);
        ahb(1'b0, 8'h00, 32'h0, rd);
        chk("bank1", {16'h0, ~v[15:0]}, rd);
        ahb(1'b1, 8'h30, 32'h0, rd);
        ahb(1'b0, 8'h00, 32'h0, rd);
        chk("bank0", {16'h0, v[15:0]}, rd);
        v = xs();
        crf_dp_model_i.wr(SEL_PAIR_LOW, v);
        dprd(SEL_DATA_ZERO, rd);
        chk("pair_low", {16'h0, v[15:0]}, rd);
        crf_dp_model_i.wr(SEL_D0_UPPER, 32'hA5);
        dprd(SEL_PAIR_LOW, rd);
        chk("byte_up", {v[31:16], 8'hA5, v[7:0]}, rd);
        crf_dp_model_i.wr(SEL_ADDR_PAIR, ~v);
        dprd(SEL_ADDR_ONE, rd);
        chk("addr_pair", {16'h0, ~v[31:16]}, rd);
        crf_dp_model_i.wr(SEL_FRAME_BASE, v);
        dprd(SEL_FRAME_BASE, rd);
        chk("frame", {16'h0, v[15:0]}, rd);
        ahb(1'b1, 8'h24, 32'h1111, rd);
        ahb(1'b1, 8'h28, 32'h2222, rd);
        dprd(SEL_STACK_ACT, rd);
        chk("stack_isp", 32'h2222, rd);
        ahb(1'b1, 8'h30, 32'h80, rd);
        dprd(SEL_STACK_ACT, rd);
        chk("stack_usp", 32'h1111, rd);
        for (int k = 0; k < 9; k++) begin
            v = (k < 3) ? (xs() & ~((32'h1 << (8 << k)) - 1)) : xs();
            rd = xs();
            crf_dp_model_i.alu(crf_size_t'(k % 3), v, rd[0], rd[1]);
            chk("alu_flags", {28'h0, fexp(crf_size_t'(k % 3), v, rd[0],
                rd[1])}, {28'h0, flags[5], flags[3:2], flags[0]});
        end
        ahb(1'b1, 8'h30, 32'h3C0, rd);
        crf_dp_model_i.irq(3'h3, ok);
        chk("irq_equal", 32'h0, {31'h0, ok});
        crf_dp_model_i.irq(3'h4, ok);
        chk("irq_above", 32'h1, {31'h0, ok});
        chk("irq_flags", 32'h300, {21'h0, flags});
        ahb(1'b1, 8'h30, 32'h80, rd);
        crf_dp_model_i.irq(3'h7, ok);
        chk("irq_masked", 32'h0, {31'h0, ok});
        crf_dp_model_i.swi(6'h20);
        chk("swi_32", 32'h80, {21'h0, flags});
        crf_dp_model_i.swi(6'h1F);
        chk("swi_31", 32'h0, {21'h0, flags});
        chk("hresp", 32'h0, {31'h0, hresp});
        results();
    end
endmodule : tb
